// File: pkg/rapm_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// Shared constants for the reset and port A pin multiplexer.
// ----------------------------------------------------------------------------
package rapm_pkg;

	// Register byte offsets on the register bus.
	localparam logic [7:0] REG_FSEL_OFS = 8'h00;
	localparam logic [7:0] REG_ACAL_OFS = 8'h04;
	localparam logic [7:0] REG_DIR_OFS = 8'h08;
	localparam logic [7:0] REG_DOUT_OFS = 8'h0c;
	localparam logic [7:0] REG_DIN_OFS = 8'h10;
	localparam logic [7:0] REG_RCTL_OFS = 8'h14;

	// Function select field: two bits per port A pin, then the reset pin mode.
	localparam int FSEL_FW = 2;
	localparam int FSEL_RGPIO_BIT = 8;
	localparam int FSEL_W = 9;

	// Function codes of a port A pin.
	localparam logic [1:0] FN_GPIO = 2'h0;
	localparam logic [1:0] FN_ANALOG = 2'h1;
	localparam logic [1:0] FN_ALT = 2'h2;

	// Converter calibration bits: reference select for pins 2 and 3.
	localparam int ACAL_REFH_BIT = 0;
	localparam int ACAL_REFL_BIT = 1;
	localparam int ACAL_W = 2;

	// Direction and data registers: bits 3..0 port A, bit 4 reset pin.
	localparam int D4_BIT = 4;
	localparam int PORT_W = 5;

	// Reset control: cause bits, write one to clear, and a request bit.
	localparam int CAUSE_POR_BIT = 0;
	localparam int CAUSE_WDOG_BIT = 1;
	localparam int CAUSE_SW_BIT = 2;
	localparam int CAUSE_PIN_BIT = 3;
	localparam int CAUSE_W = 4;
	localparam int RCTL_SWRST_BIT = 8;

	// Reset values.
	localparam logic [FSEL_W-1:0] FSEL_RST = 9'h000;
	localparam logic [ACAL_W-1:0] ACAL_RST = 2'h0;
	localparam logic [PORT_W-1:0] DIR_RST = 5'h00;
	localparam logic [PORT_W-1:0] DOUT_RST = 5'h00;
	localparam logic [CAUSE_W-1:0] CAUSE_RST = 4'h0;

endpackage : rapm_pkg
`default_nettype wire

// File: pkg/rapm_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Decoded register access between the bus slave and the register file.
// ----------------------------------------------------------------------------
interface rapm_reg_if #(
	parameter int AW = 8,
	parameter int DW = 32
);
	logic rd_stb;
	logic wr_stb;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW/8-1:0] sel;
	logic [DW-1:0] rdata;

	// The bus side issues strobes; the register side answers with data.
	modport bus (output rd_stb, wr_stb, addr, wdata, sel, input rdata);
	modport regs (input rd_stb, wr_stb, addr, wdata, sel, output rdata);
endinterface : rapm_reg_if
`default_nettype wire

// File: hdl/rapm_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Two-stage synchroniser for pin levels.
// ----------------------------------------------------------------------------
module rapm_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i, // Clock.
	input wire logic rst_i, // Synchronous reset.
	input wire logic [W-1:0] d_i, // Asynchronous levels.
	output logic [W-1:0] q_o // Synchronised levels.
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// The first stage is read only by the second stage.
	// Reset loads both stages with the idle level of each pin.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule : rapm_sync
`default_nettype wire

// File: hdl/rapm_wb_slave.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Classic Wishbone slave: one wait state, registered ack and read data.
// ----------------------------------------------------------------------------
module rapm_wb_slave #(
	parameter int AW = 8,
	parameter int DW = 32
) (
	input wire logic clk_i, // Clock.
	input wire logic rst_i, // Synchronous reset.
	input wire logic cyc_i, // Bus cycle.
	input wire logic stb_i, // Strobe.
	input wire logic we_i, // Write enable.
	input wire logic [AW-1:0] adr_i, // Byte address.
	input wire logic [DW/8-1:0] sel_i, // Byte enables.
	input wire logic [DW-1:0] dat_i, // Write data.
	output logic [DW-1:0] dat_o, // Read data.
	output logic ack_o, // Acknowledge.
	rapm_reg_if.bus rif // Decoded access.
);
	logic req;
	logic ack_q;
	logic [DW-1:0] dat_q;

	assign req = cyc_i & stb_i;

	// Ack rises one cycle after the request and falls in the next cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// Read data is captured on the edge that raises ack.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= '0;
		end else if (req && !ack_q) begin
			dat_q <= rif.rdata;
		end
	end

	// A write lands on the edge at which the master sees ack.
	assign rif.rd_stb = req & ~ack_q;
	assign rif.wr_stb = req & we_i & ack_q;
	assign rif.addr = adr_i;
	assign rif.wdata = dat_i;
	assign rif.sel = sel_i;
	assign dat_o = dat_q;
	assign ack_o = ack_q;
endmodule : rapm_wb_slave
`default_nettype wire

// File: hdl/rapm_top.sv
// Implementation choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01: Reset pin selectable as input or open-drain output.
// R02: Reset pin in port mode never resets.
// R03: Port mode: only power-on, watchdog, software reset.
// R04: Port A bit 0 leaves reset as GPIO.
// R05: Port A bits 1 to 3 leave reset GPIO.
// R06: Bit 0 analog feeds converter 0, comparator 3.
// R07: Bit 1 analog feeds converter 1, comparator 0.
// R08: Bit 2 analog: converter 2 or high reference.
// R09: Calibration bit picks bit 2 channel or reference.
// R10: Bit 3 analog: converter 3 or low reference.
// R11: Bit 0 alternate output drives comparator C output.
// R12: Calibration bit picks bit 3 channel or reference.
// R13: Every reset source restores GPIO pin functions.
module rapm_top
	import rapm_pkg::*;
#(
	parameter int AW = 8,
	parameter int DW = 32,
	parameter int PA_PINS = 4
) (
	input wire logic clk_i, // Clock, 40 MHz.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic wb_cyc_i, // Wishbone cycle.
	input wire logic wb_stb_i, // Wishbone strobe.
	input wire logic wb_we_i, // Wishbone write enable.
	input wire logic [AW-1:0] wb_adr_i, // Wishbone byte address.
	input wire logic [DW/8-1:0] wb_sel_i, // Wishbone byte enables.
	input wire logic [DW-1:0] wb_dat_i, // Wishbone write data.
	output logic [DW-1:0] wb_dat_o, // Wishbone read data.
	output logic wb_ack_o, // Wishbone acknowledge.
	input wire logic rst_pin_i, // Reset pin level.
	output logic rst_pin_o, // Reset pin drive level, always low.
	output logic rst_pin_oe_o, // Reset pin pull-down enable.
	input wire logic [PA_PINS-1:0] pa_pin_i, // Port A pin levels.
	output logic [PA_PINS-1:0] pa_pin_o, // Port A drive levels.
	output logic [PA_PINS-1:0] pa_pin_oe_o, // Port A drive enables.
	input wire logic por_i, // Power-on reset request.
	input wire logic watchdog_reset_src_i, // Watchdog reset request.
	input wire logic cmp_c_output_i, // Comparator C output.
	output logic sys_reset_o, // Device reset request.
	output logic [PA_PINS-1:0] pa_ana_en_o, // Pin in analog mode.
	output logic [PA_PINS-1:0] adc_a_chan_en_o, // Converter channel taps.
	output logic adc_a_ref_high_en_o, // Bit 2 is high reference.
	output logic adc_a_ref_low_en_o, // Bit 3 is low reference.
	output logic [PA_PINS-1:0] cmp_a_input_en_o // Comparator A taps.
);
	// ------------------------------------------------------------------------
	// Bus slave and pin synchronisers
	// ------------------------------------------------------------------------
	rapm_reg_if #(.AW(AW), .DW(DW)) rif ();

	// The slave turns each bus cycle into read and write strobes.
	rapm_wb_slave #(.AW(AW), .DW(DW)) u_wb (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cyc_i(wb_cyc_i),
		.stb_i(wb_stb_i),
		.we_i(wb_we_i),
		.adr_i(wb_adr_i),
		.sel_i(wb_sel_i),
		.dat_i(wb_dat_i),
		.dat_o(wb_dat_o),
		.ack_o(wb_ack_o),
		.rif(rif)
	);

	logic [PA_PINS+1:0] pin_s;
	logic [PA_PINS-1:0] pa_s;
	logic rst_pin_s;
	logic cmp_c_s;

	// Pins and the comparator output are asynchronous to the clock.
	// The reset pin idles high; a low reset value would fake a pin reset.
	rapm_sync #(.W(PA_PINS + 2), .RST_VAL({2'h1, {PA_PINS{1'h0}}})) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({cmp_c_output_i, rst_pin_i, pa_pin_i}),
		.q_o(pin_s)
	);

	assign pa_s = pin_s[PA_PINS-1:0];
	assign rst_pin_s = pin_s[PA_PINS];
	assign cmp_c_s = pin_s[PA_PINS+1];

	// ------------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------------
	logic [FSEL_W-1:0] fsel_q;
	logic [ACAL_W-1:0] acal_q;
	logic [PORT_W-1:0] dir_q;
	logic [PORT_W-1:0] dout_q;
	logic [CAUSE_W-1:0] cause_q;
	logic [CAUSE_W-1:0] cause_set;
	logic [CAUSE_W-1:0] cause_clr;
	logic sw_req_q;
	logic sys_reset_q;
	logic cfg_rst;
	logic pin_rst;
	logic rst_gpio;
	logic [DW-1:0] bmask;
	logic [DW-1:0] wmask;
	logic [DW-1:0] rdata;

	// Byte enables widen to a bit mask for partial writes.
	always_comb begin
		bmask = '0;
		for (int b = 0; b < DW / 8; b++) begin
			bmask[b*8 +: 8] = {8{rif.sel[b]}};
		end
	end

	assign wmask = rif.wdata & bmask;
	assign rst_gpio = fsel_q[FSEL_RGPIO_BIT];

	// Pin configuration is cleared by the bus reset and by every device reset.
	assign cfg_rst = rst_i | sys_reset_q; // [R13]

	// Function selection for port A and the reset pin mode.
	always_ff @(posedge clk_i) begin
		if (cfg_rst) begin
			fsel_q <= FSEL_RST; // [R04] [R05] [R13]
		end else if (rif.wr_stb && rif.addr == REG_FSEL_OFS) begin
			fsel_q <= (fsel_q & ~bmask[FSEL_W-1:0]) | wmask[FSEL_W-1:0];
		end
	end

	// Reference selection for port A bits 2 and 3.
	always_ff @(posedge clk_i) begin
		if (cfg_rst) begin
			acal_q <= ACAL_RST;
		end else if (rif.wr_stb && rif.addr == REG_ACAL_OFS) begin
			acal_q <= (acal_q & ~bmask[ACAL_W-1:0]) | wmask[ACAL_W-1:0]; // [R09] [R12]
		end
	end

	// Direction bits; the reset pin bit selects open-drain output.
	always_ff @(posedge clk_i) begin
		if (cfg_rst) begin
			dir_q <= DIR_RST;
		end else if (rif.wr_stb && rif.addr == REG_DIR_OFS) begin
			dir_q <= (dir_q & ~bmask[PORT_W-1:0]) | wmask[PORT_W-1:0]; // [R01]
		end
	end

	// Output data bits.
	always_ff @(posedge clk_i) begin
		if (cfg_rst) begin
			dout_q <= DOUT_RST;
		end else if (rif.wr_stb && rif.addr == REG_DOUT_OFS) begin
			dout_q <= (dout_q & ~bmask[PORT_W-1:0]) | wmask[PORT_W-1:0];
		end
	end

	// A software reset request is a one-cycle pulse from a write of one.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_req_q <= 1'b0;
		end else begin
			sw_req_q <= rif.wr_stb && rif.addr == REG_RCTL_OFS &&
				wmask[RCTL_SWRST_BIT];
		end
	end

	// The low pin resets only while the pin is not in port mode.
	assign pin_rst = ~rst_pin_s & ~rst_gpio; // [R02]

	// Reset request: in port mode only the internal sources remain.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_reset_q <= 1'b0;
		end else begin
			sys_reset_q <= por_i | watchdog_reset_src_i | sw_req_q |
				pin_rst; // [R02] [R03]
		end
	end

	// Reset causes are sticky, cleared by writing one; a new cause wins.
	always_comb begin
		cause_set = '0;
		cause_set[CAUSE_POR_BIT] = por_i;
		cause_set[CAUSE_WDOG_BIT] = watchdog_reset_src_i;
		cause_set[CAUSE_SW_BIT] = sw_req_q;
		cause_set[CAUSE_PIN_BIT] = pin_rst;
		cause_clr = '0;
		if (rif.wr_stb && rif.addr == REG_RCTL_OFS) begin
			cause_clr = wmask[CAUSE_W-1:0];
		end
	end

	// Cause bits survive device resets; of the resets, only the bus reset clears them.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cause_q <= CAUSE_RST;
		end else begin
			cause_q <= cause_set | (cause_q & ~cause_clr);
		end
	end

	// Read decode; unmapped offsets read as zero.
	always_comb begin
		rdata = '0;
		if (rif.addr == REG_FSEL_OFS) begin
			rdata[FSEL_W-1:0] = fsel_q;
		end else if (rif.addr == REG_ACAL_OFS) begin
			rdata[ACAL_W-1:0] = acal_q;
		end else if (rif.addr == REG_DIR_OFS) begin
			rdata[PORT_W-1:0] = dir_q;
		end else if (rif.addr == REG_DOUT_OFS) begin
			rdata[PORT_W-1:0] = dout_q;
		end else if (rif.addr == REG_DIN_OFS) begin
			rdata[PORT_W-1:0] = {rst_pin_s, pa_s};
		end else if (rif.addr == REG_RCTL_OFS) begin
			rdata[CAUSE_W-1:0] = cause_q;
		end
	end

	// Read data is offered only while rd_stb is high, in the first cycle of each access.
	assign rif.rdata = rif.rd_stb ? rdata : '0;

	// ------------------------------------------------------------------------
	// Port A function multiplexing
	// ------------------------------------------------------------------------
	logic [PA_PINS-1:0] pa_o_d;
	logic [PA_PINS-1:0] pa_oe_d;
	logic [PA_PINS-1:0] ana_d;
	logic [PA_PINS-1:0] chan_d;
	logic [PA_PINS-1:0] cmp_d;
	logic refh_d;
	logic refl_d;
	logic rst_oe_d;

	// Each pin picks GPIO, analog, or, on bit 0 only, the alternate output.
	for (genvar i = 0; i < PA_PINS; i++) begin : g_pin
		localparam int CI = (i + 3) % PA_PINS;
		logic [1:0] fn;
		logic alt;

		assign fn = fsel_q[i*FSEL_FW +: FSEL_FW];
		assign alt = (i == 0) && (fn == FN_ALT); // [R11]
		assign ana_d[i] = (fn == FN_ANALOG);
		assign pa_o_d[i] = alt ? cmp_c_s : dout_q[i]; // [R11]
		assign pa_oe_d[i] = alt | (~ana_d[i] & dir_q[i]);
		// Analog pin n taps comparator A input (n + 3) mod 4.
		assign cmp_d[CI] = ana_d[i]; // [R06] [R07] [R08] [R10]
		if (i == 2) begin : g_refh
			assign chan_d[i] = ana_d[i] & ~acal_q[ACAL_REFH_BIT]; // [R08] [R09]
		end else if (i == 3) begin : g_refl
			assign chan_d[i] = ana_d[i] & ~acal_q[ACAL_REFL_BIT]; // [R10] [R12]
		end else begin : g_chan
			assign chan_d[i] = ana_d[i]; // [R06] [R07]
		end
	end

	assign refh_d = ana_d[2] & acal_q[ACAL_REFH_BIT]; // [R08] [R09]
	assign refl_d = ana_d[3] & acal_q[ACAL_REFL_BIT]; // [R10] [R12]

	// The reset pin only ever pulls low, and only in port output mode.
	assign rst_oe_d = rst_gpio & dir_q[D4_BIT] & ~dout_q[D4_BIT]; // [R01]

	// ------------------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------------------
	logic [PA_PINS-1:0] pa_o_q;
	logic [PA_PINS-1:0] pa_oe_q;
	logic [PA_PINS-1:0] ana_q;
	logic [PA_PINS-1:0] chan_q;
	logic [PA_PINS-1:0] cmp_q;
	logic refh_q;
	logic refl_q;
	logic rst_oe_q;

	// All pin and routing outputs but the constant rst_pin_o are flopped to avoid glitches.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pa_o_q <= '0;
			pa_oe_q <= '0;
			ana_q <= '0;
			chan_q <= '0;
			cmp_q <= '0;
			refh_q <= 1'b0;
			refl_q <= 1'b0;
			rst_oe_q <= 1'b0;
		end else begin
			pa_o_q <= pa_o_d;
			pa_oe_q <= pa_oe_d;
			ana_q <= ana_d;
			chan_q <= chan_d;
			cmp_q <= cmp_d;
			refh_q <= refh_d;
			refl_q <= refl_d;
			rst_oe_q <= rst_oe_d;
		end
	end

	assign pa_pin_o = pa_o_q;
	assign pa_pin_oe_o = pa_oe_q;
	assign pa_ana_en_o = ana_q;
	assign adc_a_chan_en_o = chan_q;
	assign cmp_a_input_en_o = cmp_q;
	assign adc_a_ref_high_en_o = refh_q;
	assign adc_a_ref_low_en_o = refl_q;
	assign rst_pin_oe_o = rst_oe_q;
	assign rst_pin_o = 1'b0;
	assign sys_reset_o = sys_reset_q;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_r01;
		rst_pin_oe_o == ($past(rst_gpio) && $past(dir_q[D4_BIT]) &&
			!$past(dout_q[D4_BIT]));
	endproperty
	a_r01: assert property (p_r01) else $error("reset pin drive wrong"); // [R01]

	property p_r02;
		(rst_gpio && !por_i && !watchdog_reset_src_i && !sw_req_q)
			|=> !sys_reset_o;
	endproperty
	a_r02: assert property (p_r02) else $error("pin reset in port mode"); // [R02]

	property p_r03;
		(rst_gpio && (por_i || watchdog_reset_src_i || sw_req_q))
			|=> sys_reset_o;
	endproperty
	a_r03: assert property (p_r03) else $error("internal reset lost"); // [R03]

	property p_r04;
		sys_reset_o |=> ##1 (!pa_ana_en_o[0] && !adc_a_chan_en_o[0] &&
			!cmp_a_input_en_o[3] && pa_pin_oe_o[0] == 1'b0);
	endproperty
	a_r04: assert property (p_r04) else $error("bit 0 not GPIO"); // [R04]

	property p_r05;
		sys_reset_o |=> ##1 (pa_ana_en_o[3:1] == 3'h0 &&
			!adc_a_ref_high_en_o && !adc_a_ref_low_en_o);
	endproperty
	a_r05: assert property (p_r05) else $error("bits 1-3 not GPIO"); // [R05]

	property p_r06;
		pa_ana_en_o[0] |-> (adc_a_chan_en_o[0] && cmp_a_input_en_o[3]);
	endproperty
	a_r06: assert property (p_r06) else $error("bit 0 routing"); // [R06]

	property p_r07;
		pa_ana_en_o[1] |-> (adc_a_chan_en_o[1] && cmp_a_input_en_o[0]);
	endproperty
	a_r07: assert property (p_r07) else $error("bit 1 routing"); // [R07]

	property p_r08;
		pa_ana_en_o[2] |-> (cmp_a_input_en_o[1] &&
			(adc_a_chan_en_o[2] != adc_a_ref_high_en_o));
	endproperty
	a_r08: assert property (p_r08) else $error("bit 2 routing"); // [R08]

	property p_r09;
		pa_ana_en_o[2] |-> adc_a_ref_high_en_o == $past(acal_q[ACAL_REFH_BIT]);
	endproperty
	a_r09: assert property (p_r09) else $error("high ref select"); // [R09]

	property p_r10;
		pa_ana_en_o[3] |-> (cmp_a_input_en_o[2] &&
			(adc_a_chan_en_o[3] != adc_a_ref_low_en_o));
	endproperty
	a_r10: assert property (p_r10) else $error("bit 3 routing"); // [R10]

	property p_r11;
		(fsel_q[FSEL_FW-1:0] == FN_ALT) |=>
			(pa_pin_oe_o[0] && pa_pin_o[0] == $past(cmp_c_s));
	endproperty
	a_r11: assert property (p_r11) else $error("comparator C output"); // [R11]

	property p_r12;
		pa_ana_en_o[3] |-> adc_a_ref_low_en_o == $past(acal_q[ACAL_REFL_BIT]);
	endproperty
	a_r12: assert property (p_r12) else $error("low ref select"); // [R12]

	property p_r13;
		sys_reset_o |=> (fsel_q == FSEL_RST && !rst_gpio);
	endproperty
	a_r13: assert property (p_r13) else $error("config not restored"); // [R13]

endmodule : rapm_top
`default_nettype wire

// File: sim/rapm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Compare an observed value with an expected one and count the outcome.
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin \
	num_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
	$time, (act), (exp)); end end
module rapm_tb_top
	import rapm_pkg::*;
;
	logic clk_i, rst_i, cyc, stb, we, ack, por, wdog, cmpc, sys_rst;
	logic rst_pin_i, rst_pin_o, rst_pin_oe_o, refh, refl;
	logic [7:0] adr;
	logic [3:0] pa_pin_i, pa_pin_o, pa_oe, ana_en, chan_en, cmp_en;
	logic [31:0] wdat, rdat, q;
	int num_errors = 0;
	int total_checks = 0;

	// ------------------------------------------------------------------
	// Clock, design and bus helpers
	// ------------------------------------------------------------------
	// A 25 ns clock period gives 40 MHz.
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	rapm_top rapm_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
		.rst_pin_oe_o(rst_pin_oe_o), .pa_pin_i(pa_pin_i),
		.pa_pin_o(pa_pin_o), .pa_pin_oe_o(pa_oe), .por_i(por),
		.watchdog_reset_src_i(wdog), .cmp_c_output_i(cmpc),
		.sys_reset_o(sys_rst), .pa_ana_en_o(ana_en),
		.adc_a_chan_en_o(chan_en), .adc_a_ref_high_en_o(refh),
		.adc_a_ref_low_en_o(refl), .cmp_a_input_en_o(cmp_en));

	// Print the counts and the verdict, then stop the run.
	task automatic summarize();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	// One classic bus cycle held until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			num_errors++;
			summarize();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	// Let a number of clock edges pass.
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask : idle

	// Wait, bounded, for the device reset request to reach a level.
	task automatic wait_sys(input logic lvl);
		int n;
		n = 0;
		while (sys_rst !== lvl && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		if (sys_rst !== lvl) begin
			num_errors++;
			summarize();
		end
	endtask : wait_sys

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	// Port A leaves reset as GPIO, the reset pin in reset mode; unmapped reads give 0.
	task automatic t_defaults();
		`CHK({ana_en, chan_en, cmp_en, pa_oe}, 16'h0000)
		`CHK({refh, refl, rst_pin_oe_o, sys_rst}, 4'h0)
		wb(1'b0, REG_FSEL_OFS, 32'h0);
		`CHK(q, 32'h0)
		wb(1'b0, REG_ACAL_OFS, 32'h0);
		`CHK(q, 32'h0)
		wb(1'b0, REG_RCTL_OFS, 32'h0);
		`CHK(q, 32'h0)
		wb(1'b1, 8'h20, 32'hffffffff);
		wb(1'b0, 8'h20, 32'h0);
		`CHK(q, 32'h0)
	endtask : t_defaults

	// Port bits drive and read back in their general-purpose function.
	task automatic t_gpio();
		wb(1'b1, REG_DIR_OFS, 32'h0f);
		wb(1'b1, REG_DOUT_OFS, 32'h0a);
		pa_pin_i <= 4'h5;
		idle(4);
		`CHK({pa_oe, pa_pin_o}, 8'hfa)
		wb(1'b0, REG_DIN_OFS, 32'h0);
		`CHK(q[4:0], 5'h15)
	endtask : t_gpio

	// Each pin in turn goes analog; taps follow the fixed pairing.
	task automatic t_analog();
		for (int p = 0; p < 4; p++) begin
			wb(1'b1, REG_FSEL_OFS, 32'h1 << (2 * p));
			idle(3);
			`CHK({ana_en, chan_en}, {2{4'h1 << p}})
			`CHK(cmp_en, 4'h1 << ((p + 3) % 4))
			`CHK(pa_oe, 4'hf & ~(4'h1 << p))
		end
		wb(1'b1, REG_FSEL_OFS, 32'h50);
		wb(1'b1, REG_ACAL_OFS, 32'h1);
		idle(3);
		`CHK({refh, refl, chan_en, cmp_en}, 10'h286)
		wb(1'b1, REG_ACAL_OFS, 32'h2);
		idle(3);
		`CHK({refh, refl, chan_en, cmp_en}, 10'h146)
		wb(1'b1, REG_ACAL_OFS, 32'h0);
		idle(3);
		`CHK({refh, refl, chan_en}, 6'h0c)
	endtask : t_analog

	// Bit 0 alternate function carries comparator C to the pin.
	task automatic t_alt();
		wb(1'b1, REG_FSEL_OFS, 32'h2);
		cmpc <= 1'b1;
		idle(6);
		`CHK({pa_oe[0], pa_pin_o[0]}, 2'h3)
		cmpc <= 1'b0;
		idle(6);
		`CHK({pa_oe[0], pa_pin_o[0]}, 2'h2)
	endtask : t_alt

	// Pulse one reset source and confirm the pin functions come back.
	task automatic t_src(input int src);
		wb(1'b1, REG_FSEL_OFS, 32'h155);
		if (src == 2)
			wb(1'b1, REG_RCTL_OFS, 32'h100);
		else begin
			@(posedge clk_i);
			if (src == 0) por <= 1'b1;
			else wdog <= 1'b1;
			@(posedge clk_i);
			por <= 1'b0;
			wdog <= 1'b0;
		end
		wait_sys(1'b1);
		wait_sys(1'b0);
		idle(3);
		`CHK({ana_en, pa_oe}, 8'h00)
		wb(1'b0, REG_FSEL_OFS, 32'h0);
		`CHK(q, 32'h0)
		wb(1'b0, REG_RCTL_OFS, 32'h0);
		`CHK(q[src], 1'b1)
		wb(1'b1, REG_RCTL_OFS, 32'hf);
	endtask : t_src

	// Reset pin as open-drain port bit and input, ignored as a reset.
	task automatic t_rst_port();
		wb(1'b1, REG_FSEL_OFS, 32'h100);
		wb(1'b1, REG_DOUT_OFS, 32'h0);
		wb(1'b1, REG_DIR_OFS, 32'h10);
		idle(3);
		`CHK({rst_pin_oe_o, rst_pin_o}, 2'h2)
		wb(1'b1, REG_DIR_OFS, 32'h0);
		rst_pin_i <= 1'b0;
		idle(8);
		`CHK({rst_pin_oe_o, sys_rst}, 2'h0)
		wb(1'b0, REG_DIN_OFS, 32'h0);
		`CHK(q[4], 1'b0)
		rst_pin_i <= 1'b1;
		idle(4);
		for (int s = 0; s < 3; s++)
			t_src(s);
	endtask : t_rst_port

	// In reset mode a low pin resets and clears the configuration.
	task automatic t_pin_reset();
		wb(1'b1, REG_FSEL_OFS, 32'h055);
		rst_pin_i <= 1'b0;
		wait_sys(1'b1);
		rst_pin_i <= 1'b1;
		wait_sys(1'b0);
		idle(3);
		`CHK(ana_en, 4'h0)
		wb(1'b0, REG_RCTL_OFS, 32'h0);
		`CHK(q[3], 1'b1)
	endtask : t_pin_reset

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	// Drive every input at time zero, hold reset for 16 cycles, then run.
	initial begin
		rst_i = 1'b1;
		{cyc, stb, we, por, wdog, cmpc} = 6'h00;
		adr = 8'h00;
		wdat = 32'h0;
		rst_pin_i = 1'b1;
		pa_pin_i = 4'h0;
		idle(16);
		rst_i <= 1'b0;
		idle(2);
		t_defaults();
		t_gpio();
		t_analog();
		t_alt();
		t_rst_port();
		t_pin_reset();
		summarize();
	end
endmodule : rapm_tb_top
`default_nettype wire
